// file: include/loader_pkg.sv
package loader_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_QUADLET = 8'h1C;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

	localparam int BIT_RELOAD = 4;
	localparam int BIT_DONE = 3;
	localparam int BIT_ACKERR = 2;
	localparam int BIT_CKERR = 1;
	localparam int BIT_NOMEM = 0;
	localparam int ADDR_LSB = 16;
	localparam int ADDR_MSB = 25;
	localparam int LAST_FLAG_BIT = 7;

	localparam logic RELOAD_RST = 1'b1;
	localparam logic [3:0] IRQ_MASK_RST = 4'h0;

	// ----------------------------------------------------------------
	// Serial bus constants
	// ----------------------------------------------------------------
	localparam logic [7:0] DEV_WRITE = 8'hA0;
	localparam logic [7:0] DEV_READ = 8'hA1;
	localparam logic [7:0] START_ADDR_HI = 8'h00;
	localparam logic [7:0] START_ADDR_LO = 8'h00;
	localparam logic [7:0] CKSUM_SEED = 8'hAA;
	localparam logic [9:0] QUAD_STEP = 10'h004;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int SCL_QUARTER_NS = 2500;
	localparam int QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [6:0] QUARTER_LAST = 7'(QUARTER_CYC - 1);
	localparam logic [2:0] CHECK_LAST = 3'h4;
	localparam logic [3:0] ACK_BIT = 4'h8;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		CMD_START = 4'b0001,
		CMD_WRITE = 4'b0010,
		CMD_READ = 4'b0100,
		CMD_STOP = 4'b1000
	} cmd_t;

	typedef enum logic [9:0] {
		S_CHECK = 10'b00_0000_0001,
		S_START = 10'b00_0000_0010,
		S_DEVW = 10'b00_0000_0100,
		S_AHI = 10'b00_0000_1000,
		S_ALO = 10'b00_0001_0000,
		S_RSTART = 10'b00_0010_0000,
		S_DEVR = 10'b00_0100_0000,
		S_READ = 10'b00_1000_0000,
		S_STOP = 10'b01_0000_0000,
		S_END = 10'b10_0000_0000
	} state_t;

	typedef struct packed {
		logic valid;
		logic [9:0] addr;
		logic [31:0] data;
	} cfg_write_t;

endpackage : loader_pkg

// file: core/sync_2ff.sv
`timescale 1ns/1ps
module sync_2ff (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic d_i,
	output logic q_o
);
	// Pins idle high on an open-drain bus, so both stages reset high.
	logic meta_r;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			meta_r <= 1'b1;
			q_o <= 1'b1;
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule : sync_2ff

// file: core/serial_eeprom_config_loader.sv
`timescale 1ns/1ps
module serial_eeprom_config_loader
	import loader_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic irq_o,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	output cfg_write_t cfg_o
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic scl_s;
	logic sda_s;
	state_t st_r;
	cmd_t cmd_r;
	logic go_r;
	logic wait_r;
	logic [7:0] tx_byte_r;
	logic ack_send_r;
	logic busy_r;
	logic [1:0] ph_r;
	logic [6:0] tick_r;
	logic [3:0] bit_r;
	logic [7:0] txsh_r;
	logic [7:0] rxsh_r;
	logic ack_ok_r;
	logic eng_done_r;
	logic scl_drv_nxt;
	logic sda_drv_nxt;
	logic [2:0] chk_cnt_r;
	logic in_hdr_r;
	logic [1:0] hdr_idx_r;
	logic [1:0] bq_r;
	logic [7:0] qcnt_r;
	logic [9:0] tgt_r;
	logic [31:0] quad_r;
	logic [7:0] cks_r;
	logic [7:0] hdr_cks_r;
	logic last_r;
	logic fin_r;
	logic reload_r;
	logic done_r;
	logic ackerr_r;
	logic ckerr_r;
	logic nomem_r;
	logic abort_r;
	logic [3:0] ev_r;
	logic [3:0] ist_r;
	logic [3:0] imask_r;
	logic [31:0] status_word;
	logic [7:0] cks_nxt;
	logic [31:0] quad_nxt;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	sync_2ff u_sync_scl (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.d_i(scl_i),
		.q_o(scl_s)
	);

	sync_2ff u_sync_sda (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.d_i(sda_i),
		.q_o(sda_s)
	);

	// ----------------------------------------------------------------
	// Bit engine
	// ----------------------------------------------------------------
	// The clock line is driven by phase alone and never read back while
	// a byte runs, so a slave that stretches the clock is not honoured.
	always_comb begin
		scl_drv_nxt = 1'b0;
		sda_drv_nxt = 1'b0;
		unique case (cmd_r)
			CMD_START: begin
				scl_drv_nxt = (ph_r == 2'd0) || (ph_r == 2'd3);
				sda_drv_nxt = ph_r[1];
			end
			CMD_WRITE: begin
				scl_drv_nxt = (ph_r == 2'd0) || (ph_r == 2'd3);
				sda_drv_nxt = (bit_r != ACK_BIT) && !txsh_r[7];
			end
			CMD_READ: begin
				scl_drv_nxt = (ph_r == 2'd0) || (ph_r == 2'd3);
				sda_drv_nxt = (bit_r == ACK_BIT) && ack_send_r;
			end
			CMD_STOP: begin
				scl_drv_nxt = (ph_r == 2'd0);
				sda_drv_nxt = (ph_r != 2'd3);
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			busy_r <= 1'b0;
			ph_r <= 2'd0;
			tick_r <= QUARTER_LAST;
			bit_r <= 4'h0;
			txsh_r <= 8'h00;
			rxsh_r <= 8'h00;
			ack_ok_r <= 1'b0;
			eng_done_r <= 1'b0;
			scl_oe_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end else begin
			eng_done_r <= 1'b0;
			if (go_r) begin
				busy_r <= 1'b1;
				ph_r <= 2'd0;
				tick_r <= QUARTER_LAST;
				bit_r <= 4'h0;
				txsh_r <= tx_byte_r;
			end else if (busy_r) begin
				scl_oe_o <= scl_drv_nxt;
				sda_oe_o <= sda_drv_nxt;
				if (tick_r != 7'd0) begin
					tick_r <= tick_r - 7'd1;
				end else begin
					tick_r <= QUARTER_LAST;
					ph_r <= ph_r + 2'd1;
					if (ph_r == 2'd2) begin
						if (bit_r == ACK_BIT) begin
							ack_ok_r <= !sda_s;
						end else begin
							rxsh_r <= {rxsh_r[6:0], sda_s};
						end
					end
					if (ph_r == 2'd3) begin
						txsh_r <= {txsh_r[6:0], 1'b0};
						bit_r <= bit_r + 4'h1;
						if (cmd_r == CMD_START || cmd_r == CMD_STOP || bit_r == ACK_BIT) begin
							busy_r <= 1'b0;
							eng_done_r <= 1'b1;
						end
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Loader sequence
	// ----------------------------------------------------------------
	assign cks_nxt = cks_r ^ rxsh_r;
	assign quad_nxt = {rxsh_r, quad_r[31:8]};

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= S_CHECK;
			cmd_r <= CMD_START;
			go_r <= 1'b0;
			wait_r <= 1'b0;
			tx_byte_r <= 8'h00;
			ack_send_r <= 1'b0;
			chk_cnt_r <= 3'd0;
			in_hdr_r <= 1'b1;
			hdr_idx_r <= 2'd0;
			bq_r <= 2'd0;
			qcnt_r <= 8'h00;
			tgt_r <= 10'h000;
			quad_r <= 32'h0000_0000;
			cks_r <= CKSUM_SEED;
			hdr_cks_r <= 8'h00;
			last_r <= 1'b0;
			fin_r <= 1'b0;
			done_r <= 1'b0;
			ackerr_r <= 1'b0;
			ckerr_r <= 1'b0;
			nomem_r <= 1'b0;
			ev_r <= 4'h0;
			cfg_o <= '0;
		end else begin
			go_r <= 1'b0;
			ev_r <= 4'h0;
			cfg_o.valid <= 1'b0;
			if (!wait_r && st_r != S_CHECK && st_r != S_END) begin
				go_r <= 1'b1;
				wait_r <= 1'b1;
				ack_send_r <= !fin_r;
				unique case (st_r)
					S_START, S_RSTART: cmd_r <= CMD_START;
					S_STOP: cmd_r <= CMD_STOP;
					S_READ: cmd_r <= CMD_READ;
					default: cmd_r <= CMD_WRITE;
				endcase
				unique case (st_r)
					S_DEVW: tx_byte_r <= DEV_WRITE;
					S_AHI: tx_byte_r <= START_ADDR_HI;
					S_ALO: tx_byte_r <= START_ADDR_LO;
					default: tx_byte_r <= DEV_READ;
				endcase
			end
			unique case (st_r)
				S_CHECK: begin
					chk_cnt_r <= chk_cnt_r + 3'd1;
					if (chk_cnt_r == CHECK_LAST) begin
						if (!scl_s) begin
							nomem_r <= 1'b1;
							ev_r[BIT_NOMEM] <= 1'b1;
							st_r <= S_END;
						end else if (!reload_r) begin
							st_r <= S_END;
						end else begin
							st_r <= S_START;
						end
					end
				end
				S_END: begin
					if (!done_r) begin
						done_r <= 1'b1;
						ev_r[BIT_DONE] <= 1'b1;
					end
				end
				default: begin
					if (eng_done_r) begin
						wait_r <= 1'b0;
						if (st_r == S_STOP) begin
							st_r <= S_END;
						end else if (abort_r) begin
							st_r <= S_STOP;
						end else begin
							unique case (st_r)
								S_START: st_r <= S_DEVW;
								S_DEVW, S_DEVR: begin
									if (!ack_ok_r) begin
										ackerr_r <= 1'b1;
										ev_r[BIT_ACKERR] <= 1'b1;
										st_r <= S_STOP;
									end else begin
										st_r <= (st_r == S_DEVW) ? S_AHI : S_READ;
									end
								end
								S_AHI, S_ALO: begin
									if (!ack_ok_r) begin
										ackerr_r <= 1'b1;
										ev_r[BIT_ACKERR] <= 1'b1;
										st_r <= S_STOP;
									end else begin
										st_r <= (st_r == S_AHI) ? S_ALO : S_RSTART;
									end
								end
								S_RSTART: st_r <= S_DEVR;
								default: begin
									if (fin_r) begin
										st_r <= S_STOP;
									end else if (in_hdr_r) begin
										hdr_idx_r <= hdr_idx_r + 2'd1;
										unique case (hdr_idx_r)
											2'd0: tgt_r <= {rxsh_r, 2'b00};
											2'd1: qcnt_r <= rxsh_r;
											2'd2: hdr_cks_r <= rxsh_r;
											default: begin
												last_r <= rxsh_r[LAST_FLAG_BIT];
												cks_r <= CKSUM_SEED;
												bq_r <= 2'd0;
												if (qcnt_r != 8'h00) begin
													in_hdr_r <= 1'b0;
												end else if (rxsh_r[LAST_FLAG_BIT]) begin
													fin_r <= 1'b1;
												end
											end
										endcase
									end else begin
										cks_r <= cks_nxt;
										quad_r <= quad_nxt;
										bq_r <= bq_r + 2'd1;
										if (bq_r == 2'd3) begin
											cfg_o.valid <= 1'b1;
											cfg_o.addr <= tgt_r;
											cfg_o.data <= quad_nxt;
											tgt_r <= tgt_r + QUAD_STEP;
											qcnt_r <= qcnt_r - 8'h01;
											if (qcnt_r == 8'h01) begin
												if (cks_nxt != hdr_cks_r) begin
													ckerr_r <= 1'b1;
													ev_r[BIT_CKERR] <= 1'b1;
												end
												in_hdr_r <= 1'b1;
												hdr_idx_r <= 2'd0;
												fin_r <= last_r;
											end
										end
									end
								end
							endcase
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[ADDR_MSB:ADDR_LSB] = tgt_r;
		status_word[BIT_RELOAD] = reload_r;
		status_word[BIT_DONE] = done_r;
		status_word[BIT_ACKERR] = ackerr_r;
		status_word[BIT_CKERR] = ckerr_r;
		status_word[BIT_NOMEM] = nomem_r;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (rd_i) begin
			unique case (addr_i)
				OFS_STATUS: rdata_o <= status_word;
				OFS_QUADLET: rdata_o <= quad_r;
				OFS_IRQ_STAT: rdata_o <= {28'h000_0000, ist_r};
				OFS_IRQ_MASK: rdata_o <= {28'h000_0000, imask_r};
				default: rdata_o <= 32'h0000_0000;
			endcase
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end

	// A new load only ever follows a reset; the reload bit written later
	// is stored for software but does not start a second pass.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			reload_r <= RELOAD_RST;
			abort_r <= 1'b0;
			imask_r <= IRQ_MASK_RST;
		end else if (wr_i) begin
			if (addr_i == OFS_STATUS) begin
				reload_r <= wdata_i[BIT_RELOAD];
				if (wdata_i[BIT_DONE] && !done_r) begin
					abort_r <= 1'b1;
				end
			end
			if (addr_i == OFS_IRQ_MASK) begin
				imask_r <= wdata_i[3:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	// A new event beats a clearing write in the same cycle.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ist_r <= 4'h0;
			irq_o <= 1'b0;
		end else begin
			if (wr_i && addr_i == OFS_IRQ_STAT) begin
				ist_r <= (ist_r & ~wdata_i[3:0]) | ev_r;
			end else begin
				ist_r <= ist_r | ev_r;
			end
			irq_o <= |(ist_r & imask_r);
		end
	end

	// ----------------------------------------------------------------
	// Pin output levels
	// ----------------------------------------------------------------
	// Open drain: the pins only ever pull low, the enables do the work.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
		end else begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
		end
	end

endmodule : serial_eeprom_config_loader

// file: verif/serial_eeprom_config_loader_asserts.sv
`timescale 1ns/1ps
module loader_checker
	import loader_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic irq_o,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe_o,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire cfg_write_t cfg_o
);
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	a_open_drain: assert property (!scl_o && !sda_o)
		else $error("line driven high");
	// A clock line held low by someone else must never see traffic.
	a_absent_quiet: assert property (!scl_i && !scl_oe_o |-> !sda_oe_o)
		else $error("traffic without memory");
	a_scl_low_min: assert property ($rose(scl_oe_o) |=> scl_oe_o [*8])
		else $error("clock low phase short");
	a_scl_high_min: assert property ($fell(scl_oe_o) |=> !scl_oe_o [*8])
		else $error("clock high phase short");
	a_cfg_aligned: assert property (cfg_o.valid |-> cfg_o.addr[1:0] == 2'b00)
		else $error("config address unaligned");
	a_cfg_spacing: assert property (cfg_o.valid |=> !cfg_o.valid [*8])
		else $error("config writes too close");
	a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0000_0000)
		else $error("read data without read");
	a_irq_masked: assert property (wr_i && addr_i == OFS_IRQ_MASK && wdata_i[3:0] == 4'h0 |=> ##1 !irq_o)
		else $error("masked interrupt high");
endmodule : loader_checker

bind serial_eeprom_config_loader loader_checker u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.irq_o(irq_o), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe_o(sda_oe_o), .cfg_o(cfg_o));

// file: verif/eeprom_model.sv
`timescale 1ns/1ps
module eeprom_model (
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic nack_i,
	output logic sda_oe_o
);
	// ----------------------------------------------------------------
	// Serial memory
	// ----------------------------------------------------------------
	logic [7:0] mem [16];
	logic [7:0] sh = 8'h00;
	logic [7:0] cur = 8'h00;
	logic [3:0] ptr = 4'h0;
	logic rd = 1'b0;
	logic go = 1'b0;
	int bitn = 0;
	int nb = 0;
	initial sda_oe_o = 1'b0;
	// The clock fall that ends a start is not a bit, hence minus one.
	always @(negedge sda_i) begin
		if (scl_i) begin
			bitn = -1;
			nb = 0;
			rd = 1'b0;
		end
	end
	// A nack from the master ends the read so the stop is not blocked.
	always @(posedge scl_i) begin
		if (bitn < 8) sh = {sh[6:0], sda_i};
		else go = !sda_i;
	end
	always @(negedge scl_i) begin
		if (bitn == 8) begin
			bitn = 0;
			nb = nb + 1;
			sda_oe_o = 1'b0;
			if (rd && go) begin
				cur = mem[ptr];
				ptr = ptr + 4'h1;
				sda_oe_o = !cur[7];
			end
		end else begin
			bitn = bitn + 1;
			if (!rd && bitn == 8) begin
				sda_oe_o = !nack_i;
				if (nb == 2) ptr = sh[3:0];
				if (nb == 0) begin
					rd = sh[0];
					go = 1'b1;
				end
			end else if (rd && go && bitn < 8) sda_oe_o = !cur[3'(7 - bitn)];
			else sda_oe_o = 1'b0;
		end
	end
endmodule : eeprom_model

// file: verif/serial_eeprom_config_loader_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin err_total++; \
	$display("ERROR %s exp %h got %h", n, e, a); end end
module serial_eeprom_config_loader_tb_top;
	import loader_pkg::*;
	// ----------------------------------------------------------------
	// Harness
	// ----------------------------------------------------------------
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0000_0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic scl_low = 1'b0;
	logic nack = 1'b0;
	logic [31:0] rdata_o, d;
	logic irq_o, scl_o, scl_oe_o, sda_o, sda_oe_o, m_sda_oe, scl_w, sda_w;
	cfg_write_t cfg_o;
	cfg_write_t cq [$];
	int err_total = 0;
	int n_checks = 0;
	assign scl_w = !scl_oe_o && !scl_low;
	assign sda_w = !sda_oe_o && !m_sda_oe;
	serial_eeprom_config_loader u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
		.scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .cfg_o(cfg_o));
	eeprom_model u_mem (.scl_i(scl_w), .sda_i(sda_w), .nack_i(nack), .sda_oe_o(m_sda_oe));
	initial begin
		forever #12.5 clk_sys_i = !clk_sys_i;
	end
	initial begin
		u_mem.mem = '{8'h81, 8'h02, 8'hA6, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00,
			8'hFF, 8'h07, 8'hF0, 8'h07, 8'h00, 8'h00, 8'hAA, 8'h80};
	end
	always @(posedge clk_sys_i) begin
		if (cfg_o.valid) cq.push_back(cfg_o);
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd
	task automatic rst_run(input logic low, input logic nk);
		@(posedge clk_sys_i);
		rst_i <= 1'b1;
		scl_low <= low;
		nack <= nk;
		cq.delete();
		repeat (16) @(posedge clk_sys_i);
		rst_i <= 1'b0;
	endtask : rst_run
	task automatic wait_done();
		for (int i = 0; i < 45000; i++) begin
			rd(OFS_STATUS);
			if (d[BIT_DONE] === 1'b1) break;
		end
	endtask : wait_done
	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : summarize
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		rst_run(1'b0, 1'b0);
		wait_done();
		`CHK("status", 5'h1A, d[4:0])
		`CHK("cfg count", 2, cq.size())
		`CHK("cfg 0", {10'h204, 32'h0000_0002}, {cq[0].addr, cq[0].data})
		`CHK("cfg 1", {10'h208, 32'h07F0_07FF}, {cq[1].addr, cq[1].data})
		`CHK("target", 10'h000, d[25:16])
		rd(OFS_QUADLET);
		`CHK("quadlet", 32'h07F0_07FF, d)
		rd(OFS_IRQ_STAT);
		`CHK("irq stat", 32'h0000_000A, d)
		`CHK("irq idle", 1'b0, irq_o)
		wr(OFS_IRQ_MASK, 32'h0000_0008);
		repeat (2) @(posedge clk_sys_i);
		#1 `CHK("irq on", 1'b1, irq_o)
		wr(OFS_IRQ_MASK, 32'h0000_0000);
		repeat (2) @(posedge clk_sys_i);
		#1 `CHK("irq off", 1'b0, irq_o)
		wr(OFS_IRQ_STAT, 32'h0000_0008);
		rd(OFS_IRQ_STAT);
		`CHK("irq w1c", 32'h0000_0002, d)
		rd(8'h30);
		`CHK("unmapped", 32'h0000_0000, d)
		$display("test load done");
		rst_run(1'b1, 1'b0);
		wait_done();
		`CHK("status", 5'h19, d[4:0])
		`CHK("cfg count", 0, cq.size())
		rd(OFS_IRQ_STAT);
		`CHK("irq stat", 32'h0000_0009, d)
		$display("test absent done");
		rst_run(1'b0, 1'b1);
		wait_done();
		`CHK("status", 5'h1C, d[4:0])
		`CHK("cfg count", 0, cq.size())
		`CHK("bus free", 2'b00, {scl_oe_o, sda_oe_o})
		$display("test nack done");
		rst_run(1'b0, 1'b0);
		repeat (400) @(posedge clk_sys_i);
		wr(OFS_STATUS, 32'h0000_0018);
		wait_done();
		`CHK("status", 5'h18, d[4:0])
		`CHK("cfg count", 0, cq.size())
		`CHK("bus free", 2'b00, {scl_oe_o, sda_oe_o})
		$display("test abort done");
		summarize();
	end
	initial begin
		// The full load takes about 77000 cycles and the other three about 5300 cycles together.
		repeat (95000) @(posedge clk_sys_i);
		err_total++;
		summarize();
	end
endmodule : serial_eeprom_config_loader_tb_top
